// ==== hdl/power_fail_guard_rtc_update.sv ====
// Battery-backed byte array with supply-loss guard and once-a-second clock copy.
//
// Overview of operation
// - Below trip threshold, all array writes blocked.
// - Below switchover point, run from battery.
// - Deselect and reselect inside supply window.
// - Unused clock bits select fast or no-carry tests.
// - Powered: copy time into array each second.
// - On battery: keep counting, no array copy.
// - First copy one second after reselection.
`timescale 1ns/10ps
`include "rtc_guard_consts.svh"

module power_fail_guard_rtc_update
    import rtc_guard_pkg::*;
#(
    parameter int ONE_SECOND_CYCLES = `SECOND_NS / `CLK_PERIOD_NS
)
(
    // Clock and reset.
    input  wire logic  clk,
    input  wire logic  reset,
    // Supply comparators, high while the supply is above each level.
    input  wire logic  supply_above_trip,
    input  wire logic  supply_above_switchover,
    // Host SRAM bus.
    input  wire logic  chip_enable_n,
    input  wire logic  write_enable_n,
    input  wire logic  output_enable_n,
    input  wire addr_t addr,
    input  wire byte_t data_in,
    output byte_t      data_out,
    output logic       data_oe_n,
    // Status.
    output logic       deselected,
    output logic       battery_mode,
    output logic       clock_current
);

    ////////////////////////////////////////////////////////////////////////////
    // Host access decode

    logic          host_sel;
    logic          host_write;
    logic          host_read;
    logic          host_clock_write;
    logic [2:0]    host_ofs;
    logic          read_stage;
    byte_t         read_data;

    // The comparator trips before switchover, so deselect always covers battery.
    assign host_sel         = !deselected && !chip_enable_n;
    assign host_write       = host_sel && !write_enable_n;
    assign host_read        = host_sel && write_enable_n && !output_enable_n;
    assign host_clock_write = host_write && (addr >= `CLOCK_BASE);
    assign host_ofs         = addr[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // Supply guard

    logic          reselect;

    assign reselect = deselected && supply_above_trip;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            deselected <= 1'b1;
        end
        else
        begin
            deselected <= !supply_above_trip;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            battery_mode <= 1'b1;
        end
        else
        begin
            battery_mode <= !supply_above_switchover;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Second prescaler

    logic [27:0]   prescale;
    logic [27:0]   prescale_limit;
    logic          tick;
    logic          test_no_carry;
    logic          test_fast;

    // The fast test tick shortens the second so the counter races ahead.
    assign prescale_limit = test_fast ? 28'(`TEST_FAST_CYCLES)
                                      : 28'(ONE_SECOND_CYCLES);
    assign tick = (prescale == prescale_limit - 28'h1);

    // Timekeeping carries on whatever the supply does.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prescale <= 28'h0;
        end
        else if (tick || prescale >= prescale_limit)
        begin
            prescale <= 28'h0;
        end
        else
        begin
            prescale <= prescale + 28'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time counters

    logic [5:0]    seconds;
    logic [5:0]    minutes;
    logic [4:0]    hours;
    logic [2:0]    weekday;
    logic [4:0]    date;
    logic [3:0]    month;
    logic [6:0]    year;

    function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
        case (m)
            4'h2:    month_days = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            4'h4,
            4'h6,
            4'h9,
            4'hb:    month_days = 5'h1e;
            default: month_days = 5'h1f;
        endcase
    endfunction

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            seconds       <= `RST_SECONDS;
            minutes       <= `RST_MINUTES;
            hours         <= `RST_HOURS;
            weekday       <= `RST_WEEKDAY;
            date          <= `RST_DATE;
            month         <= `RST_MONTH;
            year          <= `RST_YEAR;
            test_no_carry <= 1'b0;
            test_fast     <= 1'b0;
        end
        else if (host_clock_write)
        begin
            case (host_ofs)
                `OFS_SECONDS:
                begin
                    seconds       <= data_in[5:0];
                    test_no_carry <= data_in[`BIT_TEST_NO_CARRY];
                end
                `OFS_MINUTES:
                begin
                    minutes   <= data_in[5:0];
                    test_fast <= data_in[`BIT_TEST_FAST];
                end
                `OFS_HOURS:   hours   <= data_in[4:0];
                `OFS_WEEKDAY: weekday <= data_in[2:0];
                `OFS_DATE:    date    <= data_in[4:0];
                `OFS_MONTH:   month   <= data_in[3:0];
                `OFS_YEAR:    year    <= data_in[6:0];
                default:      ;
            endcase
        end
        else if (tick)
        begin
            if (seconds < 6'h3b)
            begin
                seconds <= seconds + 6'h1;
            end
            else
            begin
                seconds <= 6'h00;
                if (!test_no_carry)
                begin
                    if (minutes < 6'h3b)
                    begin
                        minutes <= minutes + 6'h1;
                    end
                    else
                    begin
                        minutes <= 6'h00;
                        if (hours < 5'h17)
                        begin
                            hours <= hours + 5'h1;
                        end
                        else
                        begin
                            hours   <= 5'h00;
                            weekday <= (weekday == 3'h7) ? 3'h1 : weekday + 3'h1;
                            if (date < month_days(month, year))
                            begin
                                date <= date + 5'h1;
                            end
                            else
                            begin
                                date <= 5'h01;
                                if (month < 4'hc)
                                begin
                                    month <= month + 4'h1;
                                end
                                else
                                begin
                                    month <= 4'h1;
                                    year  <= (year == 7'h63) ? 7'h00 : year + 7'h1;
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    function automatic byte_t clock_byte(input logic [2:0] ofs);
        case (ofs)
            `OFS_SECONDS: clock_byte = {test_no_carry, 1'b0, seconds};
            `OFS_MINUTES: clock_byte = {test_fast, 1'b0, minutes};
            `OFS_HOURS:   clock_byte = {3'h0, hours};
            `OFS_WEEKDAY: clock_byte = {5'h00, weekday};
            `OFS_DATE:    clock_byte = {3'h0, date};
            `OFS_MONTH:   clock_byte = {4'h0, month};
            `OFS_YEAR:    clock_byte = {1'b0, year};
            default:      clock_byte = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Update holdoff after reselection

    logic [27:0]   holdoff;
    logic          start_copy;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            holdoff <= 28'h0;
        end
        else if (reselect)
        begin
            holdoff <= 28'(ONE_SECOND_CYCLES);
        end
        else if (deselected)
        begin
            holdoff <= 28'h0;
        end
        else if (holdoff != 28'h0)
        begin
            holdoff <= holdoff - 28'h1;
        end
    end

    // Until the holdoff runs out the array keeps the power-down time.
    assign start_copy = !deselected && !battery_mode
                        && ((holdoff == 28'h1) || (tick && holdoff == 28'h0));

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            clock_current <= 1'b0;
        end
        else if (deselected || reselect)
        begin
            clock_current <= 1'b0;
        end
        else if (start_copy)
        begin
            clock_current <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Copy engine

    update_state_e state;
    logic [2:0]    copy_index;
    logic          copy_write;
    logic          mem_write;
    addr_t         mem_addr;
    byte_t         mem_data;

    // Host writes win; the engine simply waits a cycle and costs no access.
    assign copy_write = (state == UPD_COPY) && !host_write
                        && !deselected && !battery_mode;
    assign mem_write  = host_write || copy_write;
    assign mem_addr   = host_write ? addr : (`CLOCK_BASE | addr_t'(copy_index));
    assign mem_data   = host_write ? data_in : clock_byte(copy_index);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state      <= UPD_IDLE;
            copy_index <= 3'h0;
        end
        else
        begin
            case (state)
                UPD_IDLE:
                begin
                    copy_index <= 3'h0;
                    if (start_copy)
                    begin
                        state <= UPD_COPY;
                    end
                end
                UPD_COPY:
                begin
                    if (deselected || battery_mode)
                    begin
                        state <= UPD_IDLE;
                    end
                    else if (copy_write)
                    begin
                        copy_index <= copy_index + 3'h1;
                        if (copy_index == 3'h7)
                        begin
                            state <= UPD_IDLE;
                        end
                    end
                end
                default: state <= UPD_IDLE;
            endcase
        end
    end

    byte_store store (
        .clk        (clk),
        .write_en   (mem_write),
        .write_addr (mem_addr),
        .write_data (mem_data),
        .read_addr  (addr),
        .read_data  (read_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            read_stage <= 1'b0;
            data_oe_n  <= 1'b1;
            data_out   <= 8'h00;
        end
        else
        begin
            read_stage <= host_read;
            // A read in flight is cut at the same edge that deselects the array.
            data_oe_n  <= !(read_stage && !deselected && supply_above_trip);
            data_out   <= read_data;
        end
    end

endmodule // power_fail_guard_rtc_update

// ==== inc/rtc_guard_consts.svh ====
// Constants for the supply-loss guard and clock update block.
`ifndef RTC_GUARD_CONSTS_SVH
`define RTC_GUARD_CONSTS_SVH

// Array geometry.
`define ARRAY_ADDR_BITS 11
`define ARRAY_DEPTH 2048

// The eight clock/calendar bytes sit at the top of the array.
`define CLOCK_BASE 11'h7f8
`define CLOCK_BYTES 4'h8
`define OFS_SECONDS 3'h0
`define OFS_MINUTES 3'h1
`define OFS_HOURS 3'h2
`define OFS_WEEKDAY 3'h3
`define OFS_DATE 3'h4
`define OFS_MONTH 3'h5
`define OFS_YEAR 3'h6
`define OFS_SPARE 3'h7

// Unused bits that select factory test modes.
`define BIT_TEST_NO_CARRY 7
`define BIT_TEST_FAST 7

// Counter reset values.
`define RST_SECONDS 6'h00
`define RST_MINUTES 6'h00
`define RST_HOURS 5'h00
`define RST_WEEKDAY 3'h1
`define RST_DATE 5'h01
`define RST_MONTH 4'h1
`define RST_YEAR 7'h00

// Timing: one second at the 4 ns clock, and the fast test tick.
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 4
`define TEST_FAST_CYCLES 16

`endif

// ==== inc/rtc_guard_pkg.sv ====
// Types shared by the supply-loss guard and clock update block.
package rtc_guard_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [10:0] addr_t;

    typedef enum logic [0:0] {
        UPD_IDLE,
        UPD_COPY
    } update_state_e;

endpackage

// ==== hdl/byte_store.sv ====
// Byte-wide array with one write port and a registered read port.
`timescale 1ns/10ps
`include "rtc_guard_consts.svh"

module byte_store
    import rtc_guard_pkg::*;
(
    // Clock.
    input  wire logic  clk,
    // Write port.
    input  wire logic  write_en,
    input  wire addr_t write_addr,
    input  wire byte_t write_data,
    // Read port.
    input  wire addr_t read_addr,
    output byte_t      read_data
);

    byte_t cells [`ARRAY_DEPTH];

    always_ff @(posedge clk)
    begin
        if (write_en)
        begin
            cells[write_addr] <= write_data;
        end
    end

    always_ff @(posedge clk)
    begin
        read_data <= cells[read_addr];
    end

endmodule // byte_store

// ==== test/power_fail_guard_rtc_update_checker.sv ====
// Port assertions for the supply guard and clock copy block.
`timescale 1ns/10ps
module power_fail_guard_rtc_update_checker
    import rtc_guard_pkg::*;
#(
    parameter int ONE_SECOND_CYCLES = 250000000
)
(
    // Watched ports.
    input wire logic clk,
    input wire logic reset,
    input wire logic supply_above_trip,
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic data_oe_n,
    input wire logic deselected,
    input wire logic battery_mode,
    input wire logic clock_current
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic rd_req;
    int   up_cnt;

    assign rd_req = !deselected && !chip_enable_n && write_enable_n && !output_enable_n;

    // Edges since reselection; it saturates so a long run cannot wrap it.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            up_cnt <= 0;
        end
        else if (deselected)
        begin
            up_cnt <= 0;
        end
        else if (up_cnt < ONE_SECOND_CYCLES + 4)
        begin
            up_cnt <= up_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////
    trip_follow_a: assert property (1'b1 |=> deselected == !$past(supply_above_trip))
        else $error("deselect misses trip");
    bat_desel_a: assert property (battery_mode |-> deselected)
        else $error("battery while selected");
    quiet_desel_a: assert property (deselected |-> data_oe_n)
        else $error("driven while deselected");
    read_lat_a: assert property (rd_req ##1 !deselected [*2] |-> !data_oe_n)
        else $error("read data late");
    oe_cause_a: assert property (!data_oe_n |-> $past(rd_req, 2))
        else $error("driven without read");
    cur_drop_a: assert property (deselected |=> !clock_current)
        else $error("current while deselected");
    copy_early_a: assert property ($rose(clock_current) |->
        up_cnt inside {[ONE_SECOND_CYCLES - 2 : ONE_SECOND_CYCLES + 1]})
        else $error("first copy off time");
    copy_late_a: assert property (up_cnt == ONE_SECOND_CYCLES + 2 |-> clock_current)
        else $error("first copy missing");
endmodule // power_fail_guard_rtc_update_checker

bind power_fail_guard_rtc_update power_fail_guard_rtc_update_checker #(
    .ONE_SECOND_CYCLES(ONE_SECOND_CYCLES)
) u_chk (
    .clk(clk), .reset(reset), .supply_above_trip(supply_above_trip),
    .chip_enable_n(chip_enable_n), .write_enable_n(write_enable_n),
    .output_enable_n(output_enable_n), .data_oe_n(data_oe_n), .deselected(deselected),
    .battery_mode(battery_mode), .clock_current(clock_current)
);

// ==== test/host_bus_model.sv ====
// Host processor model driving the byte array bus.
`timescale 1ns/10ps
module host_bus_model
    import rtc_guard_pkg::*;
(
    // Clock.
    input  wire logic  clk,
    // Bus towards the device.
    output logic       chip_enable_n,
    output logic       write_enable_n,
    output logic       output_enable_n,
    output addr_t      addr,
    output byte_t      data_in,
    input  wire byte_t data_out,
    input  wire logic  data_oe_n
);
    // Idle from time zero, so nothing strobes the array during start-up.
    initial
    begin
        chip_enable_n = 1'b1;
        write_enable_n = 1'b1;
        output_enable_n = 1'b1;
        addr = 11'h000;
        data_in = 8'h00;
    end

    function automatic byte_t live_bits(input addr_t a);
        byte_t m [8] = '{8'h3f, 8'h3f, 8'h1f, 8'h07, 8'h1f, 8'h0f, 8'h7f, 8'h00};
        return (a >= 11'h7f8) ? m[a[2:0]] : 8'hff;
    endfunction

    ////////////////////////////////////////////////////////////
    task automatic wr(input addr_t a, input byte_t d);
        @(posedge clk);
        chip_enable_n <= 1'b0;
        write_enable_n <= 1'b0;
        addr <= a;
        data_in <= d & live_bits(a);
        @(posedge clk);
        chip_enable_n <= 1'b1;
        write_enable_n <= 1'b1;
        data_in <= ~d;
    endtask

    // Skips the zero mask on purpose, to reach the factory test modes.
    task automatic wr_test(input addr_t a, input byte_t d);
        @(posedge clk);
        chip_enable_n <= 1'b0;
        write_enable_n <= 1'b0;
        addr <= a;
        data_in <= d;
        @(posedge clk);
        chip_enable_n <= 1'b1;
        write_enable_n <= 1'b1;
        data_in <= ~d;
    endtask

    task automatic rd(input addr_t a, output byte_t d, output logic o);
        @(posedge clk);
        chip_enable_n <= 1'b0;
        output_enable_n <= 1'b0;
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
        d = data_out;
        o = data_oe_n;
        @(posedge clk);
        chip_enable_n <= 1'b1;
        output_enable_n <= 1'b1;
    endtask
endmodule // host_bus_model

// ==== test/power_fail_guard_rtc_update_tb_top.sv ====
// Self-checking bench for the supply guard and clock copy block.
`timescale 1ns/10ps
`include "rtc_guard_consts.svh"
module power_fail_guard_rtc_update_tb_top
    import rtc_guard_pkg::*;
;
    localparam int SEC = 50;

    logic  clk;
    logic  reset;
    logic  trip;
    logic  sw;
    logic  ce_n;
    logic  we_n;
    logic  oe_n;
    addr_t addr;
    byte_t din;
    byte_t dout;
    logic  doe_n;
    logic  desel;
    logic  bat;
    logic  cur;
    int    n_mismatch;
    int    tests_run;
    int    seed;
    int    cyc;
    byte_t mem_m [int];
    int    aq [$];

    power_fail_guard_rtc_update #(
        .ONE_SECOND_CYCLES(SEC)
    ) u_dut (
        .clk(clk), .reset(reset), .supply_above_trip(trip), .supply_above_switchover(sw),
        .chip_enable_n(ce_n), .write_enable_n(we_n), .output_enable_n(oe_n), .addr(addr),
        .data_in(din), .data_out(dout), .data_oe_n(doe_n), .deselected(desel),
        .battery_mode(bat), .clock_current(cur)
    );
    host_bus_model u_host (
        .clk(clk), .chip_enable_n(ce_n), .write_enable_n(we_n), .output_enable_n(oe_n),
        .addr(addr), .data_in(din), .data_out(dout), .data_oe_n(doe_n)
    );

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////
    task automatic cmp(input byte_t got, input byte_t exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input addr_t a, input byte_t exp);
        byte_t d;
        logic  o;
        u_host.rd(a, d, o);
        cmp({7'h00, o}, 8'h00);
        cmp(d, exp);
    endtask

    // Seconds and minutes as copied into the array.
    task automatic ckt(input int t);
        rdc(11'h7f8, 8'(t % 60));
        rdc(11'h7f9, 8'(t / 60 % 60));
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #20000;
        n_mismatch++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end

    ////////////////////////////////////////////////////////////
    initial
    begin
        byte_t tv [7] = '{8'hba, 8'h85, 8'h03, 8'h02, 8'h0a, 8'h04, 8'h14};
        byte_t d;
        byte_t m;
        logic  o;
        int    a;
        int    t0;
        int    c0;
        int    e;
        clk = 1'b0;
        reset = 1'b1;
        trip = 1'b0;
        sw = 1'b0;
        seed = 41;
        n_mismatch = 0;
        tests_run = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        trip <= 1'b1;
        sw <= 1'b1;
        for (int i = 0; i < 20 && desel !== 1'b0; i++) @(posedge clk);
        repeat (16)
        begin
            a = $unsigned($random(seed)) % 2040;
            d = 8'($random(seed));
            u_host.wr(11'(a), d);
            mem_m[a] = d;
            aq.push_back(a);
        end
        foreach (aq[i]) rdc(11'(aq[i]), mem_m[aq[i]]);
        $display("test random_access done");
        // Strobes while deselected must leave the array and the data pins alone.
        trip <= 1'b0;
        repeat (3) @(posedge clk);
        cmp({7'h00, desel}, 8'h01);
        a = aq[0];
        u_host.wr(11'(a), ~mem_m[a]);
        u_host.rd(11'(a), d, o);
        cmp({7'h00, o}, 8'h01);
        trip <= 1'b1;
        for (int i = 0; i < 20 && desel !== 1'b0; i++) @(posedge clk);
        rdc(11'(a), mem_m[a]);
        $display("test deselect done");
        for (int j = 0; j < 7; j++) u_host.wr(11'h7f8 + 11'(j), tv[j]);
        for (int i = 0; i < 200 && cur !== 1'b1; i++) @(posedge clk);
        repeat (12) @(posedge clk);
        cmp({7'h00, cur}, 8'h01);
        // A change of the seconds byte marks a tick, which fixes the read phase.
        u_host.rd(11'h7f8, m, o);
        d = m;
        for (int i = 0; i < 20 && d === m; i++) u_host.rd(11'h7f8, d, o);
        c0 = cyc;
        u_host.rd(11'h7f9, m, o);
        t0 = int'(m) * 60 + int'(d);
        for (int k = 1; k < 4; k++)
        begin
            while (cyc < c0 + SEC * k + 4) @(posedge clk);
            ckt(t0 + k);
        end
        $display("test second_copy done");
        trip <= 1'b0;
        sw <= 1'b0;
        repeat (150) @(posedge clk);
        cmp({7'h00, bat}, 8'h01);
        sw <= 1'b1;
        trip <= 1'b1;
        for (int i = 0; i < 20 && desel !== 1'b0; i++) @(posedge clk);
        ckt(t0 + 3);
        #1;
        cmp({7'h00, cur}, 8'h00);
        for (int i = 0; i < 200 && cur !== 1'b1; i++) @(posedge clk);
        repeat (12) @(posedge clk);
        u_host.rd(11'h7f8, d, o);
        e = t0 + (cyc - c0) / SEC;
        tests_run++;
        if (d !== 8'(e % 60) && d !== 8'((e + 1) % 60))
        begin
            n_mismatch++;
            $display("MISMATCH %0t seconds %h after backup", $time, d);
        end
        $display("test battery_return done");
        // Seconds parked at 59 with the no-carry bit set must wrap alone.
        u_host.wr_test(11'h7f8, 8'h80);
        u_host.wr(11'h7f9, 8'h05);
        u_host.wr_test(11'h7f8, 8'hbb);
        repeat (SEC + 10) @(posedge clk);
        rdc(11'h7f9, 8'h05);
        u_host.rd(11'h7f8, d, o);
        cmp(d & 8'hfe, 8'h80);
        // The fast bit shortens each second to a few clocks.
        u_host.wr(11'h7f8, 8'h00);
        u_host.wr_test(11'h7f9, 8'h80);
        u_host.wr(11'h7f8, 8'h00);
        repeat (8 * `TEST_FAST_CYCLES) @(posedge clk);
        u_host.rd(11'h7f8, d, o);
        tests_run++;
        if (d !== 8'h07 && d !== 8'h08 && d !== 8'h09)
        begin
            n_mismatch++;
            $display("MISMATCH %0t fast seconds %h", $time, d);
        end
        $display("test test_modes done");
        complete_run();
    end
endmodule // power_fail_guard_rtc_update_tb_top
